// ### logic/pin_cfg_pkg.sv
package pin_cfg_pkg;
	localparam int        NUM_PINS      = 10;
	localparam int        NUM_REGS      = 5;
	localparam int        ADDR_W        = 8;
	localparam int        DATA_W        = 8;
	// register offsets, one register per pin pair
	localparam logic [7:0] ADDR_PINS_0_1 = 8'h15;
	localparam logic [7:0] ADDR_PINS_2_3 = 8'h16;
	localparam logic [7:0] ADDR_PINS_4_5 = 8'h17;
	localparam logic [7:0] ADDR_PINS_6_7 = 8'h18;
	localparam logic [7:0] ADDR_PINS_8_9 = 8'h19;
	localparam logic [7:0] CFG_RESET     = 8'h00;
	// field layout of the even pin; odd pin sits one nibble higher
	localparam int        FUNC_LSB      = 0;
	localparam int        TYPE_BIT      = 2;
	localparam int        WAKE_BIT      = 3;
	localparam int        ODD_SHIFT     = 4;
	// function codes
	localparam logic [1:0] FUNC_CODE_00  = 2'h0;
	localparam logic [1:0] FUNC_CODE_01  = 2'h1;
	localparam logic [1:0] FUNC_CODE_10  = 2'h2;
	localparam logic [1:0] FUNC_CODE_11  = 2'h3;
	// stable cycles before a debounced input changes
	localparam logic [3:0] DEBOUNCE_CYCLES = 4'h8;

	typedef enum logic [2:0] {
		MODE_ANALOG,
		MODE_RESERVED,
		MODE_DEDICATED,
		MODE_INPUT,
		MODE_OPEN_DRAIN,
		MODE_PUSH_PULL,
		MODE_SEQUENCER
	} pin_mode_t;

	// role of a pin from its index and function code
	function automatic pin_mode_t decode_mode(input int pin, input logic [1:0] code);
		pin_mode_t m;
		m = MODE_RESERVED;
		case (code)
			FUNC_CODE_00: begin
				if (pin == 0 || pin == 1 || pin == 2)
					m = MODE_ANALOG;
				else if (pin == 3 || pin == 5 || pin == 7)
					m = MODE_RESERVED;
				else
					m = MODE_DEDICATED;
			end
			FUNC_CODE_01: m = MODE_INPUT;
			FUNC_CODE_10: begin
				if (pin == 2 || pin == 7 || pin == 8 || pin == 9)
					m = MODE_SEQUENCER;
				else
					m = MODE_OPEN_DRAIN;
			end
			FUNC_CODE_11: m = MODE_PUSH_PULL;
			default: m = MODE_RESERVED;
		endcase
		return m;
	endfunction : decode_mode

	// register index that holds a pin's fields
	function automatic int reg_of(input int pin);
		return pin / 2;
	endfunction : reg_of
endpackage : pin_cfg_pkg

// ### logic/pin_function_config_0_9.sv
`timescale 1ns/100ps
module pin_function_config_0_9
	import pin_cfg_pkg::*;
(
	input  wire logic                sys_clk_in,                    // 20 mhz register clock
	input  wire logic                rst_b_in,                      // power-on reset, active low
	input  wire logic [ADDR_W-1:0]   reg_addr_in,                   // register address
	input  wire logic                reg_wr_in,                     // write strobe
	input  wire logic [DATA_W-1:0]   reg_wdata_in,                  // write data
	output logic      [DATA_W-1:0]   reg_rdata_out,                 // read data, one cycle late
	input  wire logic [NUM_PINS-1:0] pin_output_level_in,           // per-pin output level setting
	input  wire logic [NUM_PINS-1:0] seq_active_in,                 // sequencer asks output active
	input  wire logic [NUM_PINS-1:0] pin_in,                        // pad input level
	output logic      [NUM_PINS-1:0] pin_out,                       // pad output level
	output logic      [NUM_PINS-1:0] pin_oe_out,                    // pad output enable
	output logic      [NUM_PINS-1:0] io_rail_second_out,            // output powered from second rail
	output logic      [NUM_PINS-1:0] general_input_out,             // asserted state of an input pin, driven-high state of an output pin
	output logic      [NUM_PINS-1:0] wake_out,                      // wake-up pulse per pin
	output logic                     power_enable_input_out,        // power enable asserted
	output logic                     system_enable_input_out,       // system enable asserted
	output logic                     core_switch_control_out,       // core switch control asserted
	output logic                     peripheral_switch_control_out, // peripheral switch asserted
	output logic                     analog_channel_one_out,        // pin 0 routed to channel one
	output logic                     analog_channel_two_out,        // pin 1 routed to channel two
	output logic                     analog_channel_three_out,      // pin 2 routed to channel three
	output logic                     comparator_enable_out          // pin 1 comparator connected
);

	logic      [DATA_W-1:0]   cfg [NUM_REGS];
	logic      [NUM_PINS-1:0] sync_a;
	logic      [NUM_PINS-1:0] sync_b;
	logic      [NUM_PINS-1:0] filtered;
	logic      [3:0]          deb_cnt [NUM_PINS];
	logic      [NUM_PINS-1:0] asserted_prev;
	pin_mode_t                mode [NUM_PINS];
	logic      [NUM_PINS-1:0] wake_suppress;
	logic      [NUM_PINS-1:0] polarity_high;
	logic      [NUM_PINS-1:0] is_input;
	logic      [NUM_PINS-1:0] asserted;
	logic      [NUM_PINS-1:0] next_out;
	logic      [NUM_PINS-1:0] next_oe;

	// register writes; unknown addresses are ignored
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int r = 0; r < NUM_REGS; r++)
				cfg[r] <= CFG_RESET;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_PINS_0_1: cfg[0] <= reg_wdata_in;
				ADDR_PINS_2_3: cfg[1] <= reg_wdata_in;
				ADDR_PINS_4_5: cfg[2] <= reg_wdata_in;
				ADDR_PINS_6_7: cfg[3] <= reg_wdata_in;
				ADDR_PINS_8_9: cfg[4] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// registered read-back; unmapped addresses read zero
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			case (reg_addr_in)
				ADDR_PINS_0_1: reg_rdata_out <= cfg[0];
				ADDR_PINS_2_3: reg_rdata_out <= cfg[1];
				ADDR_PINS_4_5: reg_rdata_out <= cfg[2];
				ADDR_PINS_6_7: reg_rdata_out <= cfg[3];
				ADDR_PINS_8_9: reg_rdata_out <= cfg[4];
				default:       reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// field extraction per pin; odd pins use the upper nibble
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			int sh;
			sh = (p % 2) * ODD_SHIFT;
			wake_suppress[p] = cfg[reg_of(p)][WAKE_BIT + sh];
			polarity_high[p] = cfg[reg_of(p)][TYPE_BIT + sh];
			mode[p] = decode_mode(p, cfg[reg_of(p)][FUNC_LSB + sh +: 2]);
			// inputs: general input and dedicated inputs only
			is_input[p] = (mode[p] == MODE_INPUT) || (mode[p] == MODE_DEDICATED);
		end
	end

	// two-flop synchroniser for the pads
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
		end
	end

	// debounce filter; the level setting switches it on for inputs
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			filtered <= '0;
			for (int p = 0; p < NUM_PINS; p++)
				deb_cnt[p] <= 4'h0;
		end else begin
			for (int p = 0; p < NUM_PINS; p++) begin
				if (!pin_output_level_in[p]) begin
					filtered[p] <= sync_b[p];
					deb_cnt[p]  <= 4'h0;
				end else if (sync_b[p] == filtered[p]) begin
					deb_cnt[p] <= 4'h0;
				end else if (deb_cnt[p] == DEBOUNCE_CYCLES - 4'h1) begin
					filtered[p] <= sync_b[p];
					deb_cnt[p]  <= 4'h0;
				end else begin
					deb_cnt[p] <= deb_cnt[p] + 4'h1;
				end
			end
		end
	end

	// polarity applied; non-input roles never read as asserted
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++)
			asserted[p] = is_input[p] & (filtered[p] ~^ polarity_high[p]);
	end

	// wake on passive-to-active edge unless suppressed
	// history starts as active so reset itself never looks like an edge
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			asserted_prev <= '1;
			wake_out      <= '0;
		end else begin
			asserted_prev <= asserted;
			wake_out      <= asserted & ~asserted_prev & ~wake_suppress;
		end
	end

	// pad drive per role
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			next_out[p] = 1'b0;
			next_oe[p]  = 1'b0;
			case (mode[p])
				MODE_OPEN_DRAIN: begin
					next_out[p] = 1'b0;
					next_oe[p]  = ~pin_output_level_in[p];
				end
				MODE_PUSH_PULL: begin
					next_out[p] = pin_output_level_in[p];
					next_oe[p]  = 1'b1;
				end
				MODE_SEQUENCER: begin
					// level setting picks which pad level means active
					next_out[p] = seq_active_in[p] ~^ pin_output_level_in[p];
					next_oe[p]  = 1'b1;
				end
				default: begin
					next_out[p] = 1'b0;
					next_oe[p]  = 1'b0;
				end
			endcase
		end
	end

	// pad outputs and rail select registered to avoid glitches on writes
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_out            <= '0;
			pin_oe_out         <= '0;
			io_rail_second_out <= '0;
		end else begin
			pin_out            <= next_out;
			pin_oe_out         <= next_oe;
			io_rail_second_out <= polarity_high;
		end
	end

	// status and dedicated functions
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			general_input_out             <= '0;
			power_enable_input_out        <= 1'b0;
			system_enable_input_out       <= 1'b0;
			core_switch_control_out       <= 1'b0;
			peripheral_switch_control_out <= 1'b0;
		end else begin
			// status bit follows the pin's asserted input, or its drive when output
			for (int p = 0; p < NUM_PINS; p++)
				general_input_out[p] <= is_input[p] ? asserted[p] : (next_oe[p] & next_out[p]);
			power_enable_input_out        <= (mode[9] == MODE_DEDICATED) & asserted[9];
			system_enable_input_out       <= (mode[8] == MODE_DEDICATED) & asserted[8];
			core_switch_control_out       <= (mode[4] == MODE_DEDICATED) & asserted[4];
			peripheral_switch_control_out <= (mode[6] == MODE_DEDICATED) & asserted[6];
		end
	end

	// analog routing
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			analog_channel_one_out   <= 1'b0;
			analog_channel_two_out   <= 1'b0;
			analog_channel_three_out <= 1'b0;
			comparator_enable_out    <= 1'b0;
		end else begin
			analog_channel_one_out   <= (mode[0] == MODE_ANALOG);
			analog_channel_two_out   <= (mode[1] == MODE_ANALOG);
			analog_channel_three_out <= (mode[2] == MODE_ANALOG);
			comparator_enable_out    <= (mode[1] == MODE_ANALOG);
		end
	end

endmodule : pin_function_config_0_9

// ### tb/pin_cfg_props.sv
`timescale 1ns/100ps
module pin_cfg_props
	import pin_cfg_pkg::*;
(
	input wire logic                sys_clk_in, rst_b_in, reg_wr_in,
	input wire logic [ADDR_W-1:0]   reg_addr_in,
	input wire logic [DATA_W-1:0]   reg_wdata_in, reg_rdata_out,
	input wire logic [NUM_PINS-1:0] pin_output_level_in, seq_active_in, pin_in, pin_out, pin_oe_out,
	input wire logic [NUM_PINS-1:0] io_rail_second_out, general_input_out, wake_out,
	input wire logic                power_enable_input_out, system_enable_input_out, core_switch_control_out,
	input wire logic                peripheral_switch_control_out, analog_channel_one_out, analog_channel_two_out,
	input wire logic                analog_channel_three_out, comparator_enable_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// mapped write, then address held with no write
	sequence s_wr; reg_wr_in && reg_addr_in >= ADDR_PINS_0_1 && reg_addr_in <= ADDR_PINS_8_9; endsequence
	sequence s_hold; !reg_wr_in && reg_addr_in == $past(reg_addr_in); endsequence
	property p_readback; s_wr ##1 s_hold |=> reg_rdata_out == $past(reg_wdata_in, 2); endproperty
	a_readback: assert property (p_readback) else $error("readback differs from write");
	property p_unmapped; reg_addr_in < ADDR_PINS_0_1 || reg_addr_in > ADDR_PINS_8_9 |=> reg_rdata_out == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_wake_pulse; (|wake_out) |=> (wake_out & $past(wake_out)) == 10'h000; endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
	property p_wake_cause; (|wake_out) |-> (wake_out & ~general_input_out) == 10'h000; endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without asserted input");
	property p_analog_one; analog_channel_one_out |-> !pin_oe_out[0] && !wake_out[0]; endproperty
	a_analog_one: assert property (p_analog_one) else $error("analog pin 0 active digitally");
	property p_analog_two; analog_channel_two_out |-> comparator_enable_out && !pin_oe_out[1] && !wake_out[1]; endproperty
	a_analog_two: assert property (p_analog_two) else $error("pin 1 analog routing wrong");
	property p_analog_three; analog_channel_three_out |-> !pin_oe_out[2] && !general_input_out[2]; endproperty
	a_analog_three: assert property (p_analog_three) else $error("analog pin 2 active digitally");
	property p_enables; !(power_enable_input_out && pin_oe_out[9]) && !(system_enable_input_out && pin_oe_out[8]); endproperty
	a_enables: assert property (p_enables) else $error("enable input pin driving");
	property p_switch; $rose(core_switch_control_out) |-> general_input_out[4] && !pin_oe_out[4]; endproperty
	a_switch: assert property (p_switch) else $error("core switch without input status");
endmodule : pin_cfg_props

// ### tb/pin_pad_model.sv
`timescale 1ns/100ps
module pin_pad_model
	import pin_cfg_pkg::*;
(
	input  wire logic [NUM_PINS-1:0] drive_in,     // device drive value
	input  wire logic [NUM_PINS-1:0] drive_en_in,  // device drives the pad
	input  wire logic [NUM_PINS-1:0] ext_level_in, // outside circuit level
	output logic      [NUM_PINS-1:0] pad_out       // resolved pad level
);
	// a released pad follows the outside circuit, never the last driven value
	always_comb pad_out = (drive_en_in & drive_in) | (~drive_en_in & ext_level_in);
endmodule : pin_pad_model

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	import pin_cfg_pkg::*;
	typedef struct { int what; logic [9:0] val; } note_t;
	logic       sys_clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d;
	logic [9:0] pin_output_level_in = 10'h000, seq_active_in = 10'h000, ext_level = 10'h000;
	logic [9:0] pin_in, pin_out, pin_oe_out, io_rail_second_out, general_input_out, wake_out, mask, lvl;
	logic       power_enable_input_out, system_enable_input_out, core_switch_control_out;
	logic       peripheral_switch_control_out, analog_channel_one_out, analog_channel_two_out;
	logic       analog_channel_three_out, comparator_enable_out;
	int         n_fail = 0, total_checks = 0, cycles = 0, seed = 48;
	note_t      notes[$];
	event       chk_ev;
	string      names[7] = '{"rdata", "oe", "out", "rail", "status", "wake", "dedicated"};

	always #25 sys_clk_in = ~sys_clk_in;
	pin_function_config_0_9 uut (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .pin_output_level_in(pin_output_level_in),
		.seq_active_in(seq_active_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
		.io_rail_second_out(io_rail_second_out), .general_input_out(general_input_out), .wake_out(wake_out),
		.power_enable_input_out(power_enable_input_out), .system_enable_input_out(system_enable_input_out),
		.core_switch_control_out(core_switch_control_out),
		.peripheral_switch_control_out(peripheral_switch_control_out),
		.analog_channel_one_out(analog_channel_one_out), .analog_channel_two_out(analog_channel_two_out),
		.analog_channel_three_out(analog_channel_three_out), .comparator_enable_out(comparator_enable_out)
	);
	pin_pad_model pads (.drive_in(pin_out), .drive_en_in(pin_oe_out), .ext_level_in(ext_level), .pad_out(pin_in));

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#2;
	endtask : cyc
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic note(input int what, input logic [9:0] val);
		notes.push_back('{what, val});
		-> chk_ev;
	endtask : note
	// write strobe drops for a full cycle so back-to-back calls never re-drive it in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		reg_addr_in = a;
		reg_wdata_in = dat;
		reg_wr_in = 1'b1;
		cyc(1);
		reg_wr_in = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_in = a;
		cyc(1);
		note(0, {2'h0, e});
	endtask : rd
	task automatic all(input logic [7:0] dat);
		for (int a = 8'h15; a <= 8'h19; a++) wr(8'(a), dat);
		cyc(2);
	endtask : all
	task automatic complete_run;
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run

	// monitor: compares outputs against the oldest notes
	always begin : monitor
		logic [9:0] seen [7];
		@(chk_ev);
		seen = '{{2'h0, reg_rdata_out}, pin_oe_out, pin_out, io_rail_second_out, general_input_out, wake_out,
			{2'h0, analog_channel_three_out, analog_channel_two_out, analog_channel_one_out, comparator_enable_out,
			power_enable_input_out, system_enable_input_out, core_switch_control_out, peripheral_switch_control_out}};
		while (notes.size() > 0) begin
			check(names[notes[0].what], seen[notes[0].what], notes[0].val);
			void'(notes.pop_front());
		end
	end

	// hang guard, far above the roughly 210 cycles the run needs
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		cyc(12);
		rst_b_in = 1'b1;
		cyc(3);
		for (int a = 8'h15; a <= 8'h19; a++) rd(8'(a), 8'h00);
		note(5, 10'h000);
		note(1, 10'h000);
		note(6, 10'h0ff);
		note(4, 10'h350);
		ext_level = 10'h3ff;
		cyc(6);
		note(6, 10'h0f0);
		note(4, 10'h000);
		wr(8'h1a, 8'hff);
		rd(8'h1a, 8'h00);
		rd(8'h14, 8'h00);
		for (int a = 8'h15; a <= 8'h19; a++) begin
			d = 8'($random(seed));
			wr(8'(a), d);
			rd(8'(a), d);
		end
		// push-pull on both rails
		for (int t = 0; t < 2; t++) begin
			all(t ? 8'h77 : 8'h33);
			lvl = 10'($random(seed));
			pin_output_level_in = lvl;
			cyc(2);
			note(1, 10'h3ff);
			note(2, lvl);
			note(3, t ? 10'h3ff : 10'h000);
		end
		// open drain on most pins, sequencer on 2,7,8,9
		all(8'h22);
		repeat (4) begin
			lvl = 10'($random(seed));
			mask = 10'($random(seed));
			pin_output_level_in = lvl;
			seq_active_in = mask;
			cyc(2);
			note(1, (~lvl & 10'h07b) | 10'h384);
			note(2, ~(mask ^ lvl) & 10'h384);
		end
		// active-high inputs with wake, debounce off
		pin_output_level_in = 10'h000;
		ext_level = 10'h000;
		all(8'h55);
		cyc(6);
		mask = 10'($random(seed));
		ext_level = mask;
		cyc(4);
		note(5, mask);
		note(4, mask);
		cyc(1);
		note(5, 10'h000);
		// active-low inputs with wake suppressed
		ext_level = 10'h3ff;
		all(8'h99);
		cyc(6);
		ext_level = ~mask;
		cyc(4);
		note(5, 10'h000);
		note(4, mask);
		// debounce delays the change
		ext_level = 10'h000;
		pin_output_level_in = 10'h3ff;
		all(8'h55);
		cyc(20);
		ext_level = mask;
		cyc(4);
		note(4, 10'h000);
		cyc(12);
		note(4, mask);
		// reserved and analog pins stay inert, dedicated inputs wake
		pin_output_level_in = 10'h000;
		ext_level = 10'h3ff;
		all(8'h00);
		cyc(6);
		ext_level = 10'h000;
		cyc(4);
		note(5, 10'h350);
		note(6, 10'h0ff);
		complete_run();
	end
endmodule : testbench

bind pin_function_config_0_9 pin_cfg_props props (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .pin_output_level_in(pin_output_level_in),
	.seq_active_in(seq_active_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
	.io_rail_second_out(io_rail_second_out), .general_input_out(general_input_out), .wake_out(wake_out),
	.power_enable_input_out(power_enable_input_out), .system_enable_input_out(system_enable_input_out),
	.core_switch_control_out(core_switch_control_out),
	.peripheral_switch_control_out(peripheral_switch_control_out),
	.analog_channel_one_out(analog_channel_one_out), .analog_channel_two_out(analog_channel_two_out),
	.analog_channel_three_out(analog_channel_three_out), .comparator_enable_out(comparator_enable_out)
);
